// file: acmc_cfg.svh
`ifndef ACMC_CFG_SVH
`define ACMC_CFG_SVH

// register byte offsets on the bus
`define ACMC_OFF_CTRL 12'h000
`define ACMC_OFF_IRQ_STAT 12'h004
`define ACMC_OFF_IRQ_MASK 12'h008

// field positions of the status/control register
`define ACMC_BIT_ON 7
`define ACMC_BIT_REFSEL 6
`define ACMC_BIT_FLAG 5
`define ACMC_BIT_IE 4
`define ACMC_BIT_LEVEL 3
`define ACMC_BIT_OPE 2
`define ACMC_EDGE_HI 1
`define ACMC_EDGE_LO 0

// edge-select codes
`define ACMC_EDGE_FALL0 2'h0
`define ACMC_EDGE_RISE 2'h1
`define ACMC_EDGE_FALL2 2'h2
`define ACMC_EDGE_BOTH 2'h3

// reset values
`define ACMC_CTRL_RESET 8'h00
`define ACMC_MASK_RESET 2'h0

// interrupt status layout: bit 0 rising seen, bit 1 falling seen
`define ACMC_IST_RISE 0
`define ACMC_IST_FALL 1

// bus answers
`define ACMC_RESP_OKAY 2'h0
`define ACMC_RESP_SLVERR 2'h2

`endif

// file: acmc_pkg.sv
package acmc_pkg;

    typedef struct packed {
        logic on;
        logic reference_select;
        logic irq_enable;
        logic output_pin_enable;
        logic [1:0] edge_select;
    } acmc_ctrl_t;

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic level_d;
    } acmc_sync_t;

    typedef struct packed {
        logic rise;
        logic fall;
    } acmc_edge_t;

    typedef enum {
        ACMC_W_IDLE,
        ACMC_W_RESP
    } acmc_wstate_t;

    typedef enum {
        ACMC_R_IDLE,
        ACMC_R_RESP
    } acmc_rstate_t;

endpackage

// file: acmc_sync.sv
`timescale 1ns/1ps
module acmc_sync (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic async_level,
    input wire logic enable,
    output acmc_pkg::acmc_edge_t edges,
    output logic level
);
    import acmc_pkg::*;

    acmc_sync_t state;
    acmc_sync_t next_state;

    always_comb begin
        next_state = state;
        next_state.sync1 = async_level;
        next_state.sync2 = state.sync1;
        next_state.level_d = enable & state.sync2;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // only the second and third stages feed logic; disabled level holds at zero
    assign level = state.level_d;
    assign edges.rise = enable & state.sync2 & ~state.level_d;
    assign edges.fall = enable & ~state.sync2 & state.level_d;

    sync_zero_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !enable |=> !level)
        else $error("level not zero while disabled");
endmodule

// file: acmc_event.sv
`timescale 1ns/1ps
`include "acmc_cfg.svh"
module acmc_event (
    input wire logic [1:0] edge_select,
    input acmc_pkg::acmc_edge_t edges,
    output logic event_hit
);
    import acmc_pkg::*;

    always_comb begin
        case (edge_select)
            `ACMC_EDGE_RISE: event_hit = edges.rise;
            `ACMC_EDGE_BOTH: event_hit = edges.rise | edges.fall;
            default: event_hit = edges.fall;
        endcase
    end
endmodule

// file: acmc_top.sv
// Overview of operation
// - bit 7 turns the comparator on
// - bit 6 picks pin or bandgap reference
// - selected edge sets event flag bit 5
// - writing one clears the event flag
// - bit 4 gates flag onto interrupt request
// - bit 3 reads live level, zero when off
// - bit 2 drives level onto output pin
// - edge codes: 00 fall, 01 rise, 10 fall, 11 both
// - output high when non-inverting input is higher
// - stop modes force the comparator off
`timescale 1ns/1ps
`include "acmc_cfg.svh"
module acmc_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic comparator_raw,
    input wire logic stop_mode,
    output logic comparator_on,
    output logic reference_select,
    output logic comparator_out_pin,
    output logic comparator_out_pin_oe,
    output logic event_irq,
    output logic irq
);
    import acmc_pkg::*;

    typedef struct packed {
        acmc_wstate_t wst;
        acmc_rstate_t rst;
        logic aw_have;
        logic w_have;
        logic [11:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic [1:0] bresp;
        logic [31:0] rdata;
        logic [1:0] rresp;
        acmc_ctrl_t ctrl;
        logic flag;
        logic [1:0] ist;
        logic [1:0] imask;
        logic stop_s1;
        logic stop_s2;
        logic pin;
        logic pin_oe;
        logic event_irq;
        logic irq;
        logic on_out;
        logic awready;
        logic wready;
        logic bvalid;
        logic arready;
        logic rvalid;
    } acmc_state_t;

    acmc_state_t st;
    acmc_state_t next_st;

    logic active;
    logic level;
    logic event_hit;
    acmc_edge_t edges;

    // stop mode is a pin-level input, so it is synchronised first
    assign active = st.ctrl.on & ~st.stop_s2;

    // analog core compares the chosen inputs; raw result is async
    acmc_sync u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_level(comparator_raw),
        .enable(active),
        .edges(edges),
        .level(level)
    );

    acmc_event u_event (
        .edge_select(st.ctrl.edge_select),
        .edges(edges),
        .event_hit(event_hit)
    );

    function automatic logic [7:0] status_byte(input acmc_state_t s, input logic lv);
        logic [7:0] b;
        b = 8'h00;
        b[`ACMC_BIT_ON] = s.ctrl.on;
        b[`ACMC_BIT_REFSEL] = s.ctrl.reference_select;
        b[`ACMC_BIT_FLAG] = s.flag;
        b[`ACMC_BIT_IE] = s.ctrl.irq_enable;
        b[`ACMC_BIT_LEVEL] = lv;
        b[`ACMC_BIT_OPE] = s.ctrl.output_pin_enable;
        b[`ACMC_EDGE_HI:`ACMC_EDGE_LO] = s.ctrl.edge_select;
        return b;
    endfunction

    logic wr_fire;
    logic rd_fire;
    logic [7:0] wbyte;
    logic wlane0;

    always_comb begin
        next_st = st;
        wr_fire = 1'b0;
        rd_fire = 1'b0;
        wbyte = st.wdata[7:0];
        wlane0 = st.wstrb[0];
        next_st.stop_s1 = stop_mode;
        next_st.stop_s2 = st.stop_s1;

        // write channel capture, address and data in either order
        if (s_axi_awvalid && st.awready) begin
            next_st.aw_have = 1'b1;
            next_st.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st.wready) begin
            next_st.w_have = 1'b1;
            next_st.wdata = s_axi_wdata;
            next_st.wstrb = s_axi_wstrb;
        end

        case (st.wst)
            ACMC_W_IDLE: begin
                if (st.aw_have && st.w_have) begin
                    wr_fire = 1'b1;
                    next_st.aw_have = 1'b0;
                    next_st.w_have = 1'b0;
                    next_st.bresp = `ACMC_RESP_OKAY;
                    next_st.wst = ACMC_W_RESP;
                end
            end
            ACMC_W_RESP: begin
                if (s_axi_bready) begin
                    next_st.wst = ACMC_W_IDLE;
                end
            end
            default: next_st.wst = ACMC_W_IDLE;
        endcase

        // hardware set beats a same-cycle software clear
        if (wr_fire) begin
            if (st.awaddr == `ACMC_OFF_CTRL) begin
                if (wlane0) begin
                    next_st.ctrl.on = wbyte[`ACMC_BIT_ON];
                    next_st.ctrl.reference_select = wbyte[`ACMC_BIT_REFSEL];
                    next_st.ctrl.irq_enable = wbyte[`ACMC_BIT_IE];
                    next_st.ctrl.output_pin_enable = wbyte[`ACMC_BIT_OPE];
                    next_st.ctrl.edge_select = wbyte[`ACMC_EDGE_HI:`ACMC_EDGE_LO];
                    if (wbyte[`ACMC_BIT_FLAG]) begin
                        next_st.flag = 1'b0;
                    end
                end
            end else if (st.awaddr == `ACMC_OFF_IRQ_MASK) begin
                if (wlane0) begin
                    next_st.imask = wbyte[1:0];
                end
            end else if (st.awaddr == `ACMC_OFF_IRQ_STAT) begin
                next_st.bresp = `ACMC_RESP_OKAY;
            end else begin
                next_st.bresp = `ACMC_RESP_SLVERR;
            end
        end

        // read channel
        case (st.rst)
            ACMC_R_IDLE: begin
                if (s_axi_arvalid && st.arready) begin
                    rd_fire = 1'b1;
                    next_st.rst = ACMC_R_RESP;
                    next_st.rresp = `ACMC_RESP_OKAY;
                    if (s_axi_araddr == `ACMC_OFF_CTRL) begin
                        next_st.rdata = {24'h00_0000, status_byte(st, level)};
                    end else if (s_axi_araddr == `ACMC_OFF_IRQ_STAT) begin
                        next_st.rdata = {30'h000_0000, st.ist};
                        next_st.ist = 2'h0;
                    end else if (s_axi_araddr == `ACMC_OFF_IRQ_MASK) begin
                        next_st.rdata = {30'h000_0000, st.imask};
                    end else begin
                        next_st.rdata = 32'h0000_0000;
                        next_st.rresp = `ACMC_RESP_SLVERR;
                    end
                end
            end
            ACMC_R_RESP: begin
                if (s_axi_rready) begin
                    next_st.rst = ACMC_R_IDLE;
                end
            end
            default: next_st.rst = ACMC_R_IDLE;
        endcase

        if (event_hit) begin
            next_st.flag = 1'b1;
        end
        if (edges.rise) begin
            next_st.ist[`ACMC_IST_RISE] = 1'b1;
        end
        if (edges.fall) begin
            next_st.ist[`ACMC_IST_FALL] = 1'b1;
        end

        next_st.pin = st.ctrl.output_pin_enable & level;
        next_st.pin_oe = st.ctrl.output_pin_enable & active;
        next_st.event_irq = next_st.ctrl.irq_enable & next_st.flag;
        next_st.irq = |(next_st.ist & next_st.imask);
        // power is cut in stop whatever software left in the enable bit
        next_st.on_out = next_st.ctrl.on & ~next_st.stop_s2;
        next_st.awready = next_st.wst == ACMC_W_IDLE && !next_st.aw_have;
        next_st.wready = next_st.wst == ACMC_W_IDLE && !next_st.w_have;
        next_st.bvalid = next_st.wst == ACMC_W_RESP;
        next_st.arready = next_st.rst == ACMC_R_IDLE;
        next_st.rvalid = next_st.rst == ACMC_R_RESP;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
            st.wst <= ACMC_W_IDLE;
            st.rst <= ACMC_R_IDLE;
        end else begin
            st <= next_st;
        end
    end

    // comparator_on is a registered enable gated by the synced stop level
    assign comparator_on = st.on_out;
    assign reference_select = st.ctrl.reference_select;
    assign comparator_out_pin = st.pin;
    assign comparator_out_pin_oe = st.pin_oe;
    assign event_irq = st.event_irq;
    assign irq = st.irq;
    assign s_axi_awready = st.awready;
    assign s_axi_wready = st.wready;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_arready = st.arready;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rdata = st.rdata;
    assign s_axi_rresp = st.rresp;

    flag_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
        event_hit |=> st.flag)
        else $error("event did not set flag");

    flag_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_fire && st.awaddr == `ACMC_OFF_CTRL && wlane0 && wbyte[`ACMC_BIT_FLAG]
        && !event_hit |=> !st.flag)
        else $error("write one did not clear flag");

    flag_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
        st.flag && !(wr_fire && wbyte[`ACMC_BIT_FLAG]) |=> st.flag)
        else $error("flag dropped without clear");

    irq_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ##1 event_irq == (st.ctrl.irq_enable && st.flag))
        else $error("interrupt request mismatch");

    level_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !active ##1 !active |-> !level)
        else $error("level visible while off");

    pin_drive_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !st.ctrl.output_pin_enable |=> !comparator_out_pin_oe && !comparator_out_pin)
        else $error("pin driven while disabled");

    edge_rise_a: assert property (@(posedge aclk) disable iff (!aresetn)
        st.ctrl.edge_select == `ACMC_EDGE_RISE && edges.fall && !edges.rise |-> !event_hit)
        else $error("falling edge hit in rise mode");

    stop_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
        st.stop_s2 |-> !active ##1 !edges.rise && !edges.fall)
        else $error("comparator active in stop");

    reset_clear_a: assert property (@(posedge aclk)
        !aresetn |=> !st.ctrl.on && !st.flag && !st.ctrl.irq_enable)
        else $error("reset did not clear control");

    stop_power_a: assert property (@(posedge aclk) disable iff (!aresetn)
        st.stop_s2 |-> !comparator_on)
        else $error("comparator powered in stop");

    pin_follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
        st.ctrl.output_pin_enable |=> comparator_out_pin == $past(level))
        else $error("pin does not follow level");

    aw_capture_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("address ready stayed high after capture");
endmodule

// file: acmc_analog_model.sv
`timescale 1ns/1ps
module acmc_analog_model #(
    parameter int BANDGAP_MV = 1200
) (
    input wire logic comparator_on,
    input wire logic reference_select,
    input int pos_mv,
    input int neg_mv,
    output logic comparator_raw
);
    int plus_mv;
    assign plus_mv = reference_select ? BANDGAP_MV : pos_mv;
    // a powered-down stage parks low
    assign comparator_raw = comparator_on && (plus_mv > neg_mv);
endmodule

// file: tb_acmc_top.sv
`timescale 1ns/1ps
`include "acmc_cfg.svh"
module tb_acmc_top;
    logic aclk = 0;
    logic aresetn = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, stop_mode = 0;
    logic [11:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0;
    logic awready, wready, bvalid, arready, rvalid, raw, on, refsel, pin, oe, event_irq, irq;
    logic [1:0] bresp, rresp, rs;
    logic [31:0] rdata, rd;
    int pos_mv = 100, neg_mv = 500, num_errors = 0, checks = 0;

    always #4 aclk = ~aclk;

    acmc_top acmc_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .comparator_raw(raw), .stop_mode(stop_mode),
        .comparator_on(on), .reference_select(refsel), .comparator_out_pin(pin),
        .comparator_out_pin_oe(oe), .event_irq(event_irq), .irq(irq));

    acmc_analog_model acmc_analog_model_inst (.comparator_on(on), .reference_select(refsel),
        .pos_mv(pos_mv), .neg_mv(neg_mv), .comparator_raw(raw));

    task automatic test_done();
        if (num_errors == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        checks++;
        if (s !== e) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic cb(input string nm, input logic e, input logic s);
        chk(nm, {31'h0, e}, {31'h0, s});
    endtask

    task automatic axw(input logic [11:0] a, input logic [7:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        repeat (40) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 0;
            if (wvalid && wready) wvalid <= 0;
            if (bvalid) begin
                bready <= 0;
                rs = bresp;
                return;
            end
        end
        num_errors++;
        test_done();
    endtask

    task automatic axr(input logic [11:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        repeat (40) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 0;
            if (rvalid) begin
                rready <= 0;
                rd = rdata;
                rs = rresp;
                return;
            end
        end
        num_errors++;
        test_done();
    endtask

    // six edges cover the two-flop sync plus the gated stage
    task automatic vin(input int p);
        @(posedge aclk);
        pos_mv <= p;
        repeat (6) @(posedge aclk);
    endtask

    task automatic t_reset();
        axr(`ACMC_OFF_CTRL);
        chk("ctrl", 32'h0, rd);
        axr(`ACMC_OFF_IRQ_MASK);
        chk("mask", 32'h0, rd);
        cb("on", 0, on);
        cb("event_irq", 0, event_irq);
    endtask

    task automatic t_enable();
        axw(`ACMC_OFF_CTRL, 8'hC0);
        cb("on", 1, on);
        cb("refsel", 1, refsel);
        @(posedge aclk);
        stop_mode <= 1;
        repeat (3) @(posedge aclk);
        cb("on stop", 0, on);
        stop_mode <= 0;
        repeat (3) @(posedge aclk);
        cb("on", 1, on);
        axw(`ACMC_OFF_CTRL, 8'h00);
        cb("on", 0, on);
    endtask

    task automatic t_level();
        axw(`ACMC_OFF_CTRL, 8'hC4);
        repeat (6) @(posedge aclk);
        axr(`ACMC_OFF_CTRL);
        cb("level", 1, rd[3]);
        cb("pin", 1, pin);
        cb("oe", 1, oe);
        axw(`ACMC_OFF_CTRL, 8'h84);
        repeat (6) @(posedge aclk);
        axr(`ACMC_OFF_CTRL);
        cb("level", 0, rd[3]);
        cb("pin", 0, pin);
        vin(900);
        axr(`ACMC_OFF_CTRL);
        cb("level", 1, rd[3]);
        axw(`ACMC_OFF_CTRL, 8'h80);
        @(posedge aclk);
        cb("oe", 0, oe);
        axw(`ACMC_OFF_CTRL, 8'h04);
        axr(`ACMC_OFF_CTRL);
        cb("level off", 0, rd[3]);
        vin(100);
    endtask

    task automatic t_edges();
        for (int c = 0; c < 4; c++) begin
            axw(`ACMC_OFF_CTRL, 8'h90 | 8'(c));
            repeat (6) @(posedge aclk);
            axw(`ACMC_OFF_CTRL, 8'hB0 | 8'(c));
            vin(900);
            axr(`ACMC_OFF_CTRL);
            cb("flag rise", c[0], rd[5]);
            cb("event_irq", c[0], event_irq);
            axw(`ACMC_OFF_CTRL, 8'h90 | 8'(c));
            axr(`ACMC_OFF_CTRL);
            cb("flag kept", c[0], rd[5]);
            axw(`ACMC_OFF_CTRL, 8'hB0 | 8'(c));
            axr(`ACMC_OFF_CTRL);
            cb("flag clear", 0, rd[5]);
            vin(100);
            axr(`ACMC_OFF_CTRL);
            cb("flag fall", c != 1, rd[5]);
            axw(`ACMC_OFF_CTRL, 8'h80 | 8'(c));
            cb("event_irq off", 0, event_irq);
        end
    endtask

    task automatic t_irq();
        cb("irq masked", 0, irq);
        axr(`ACMC_OFF_IRQ_STAT);
        chk("status", 32'h3, rd);
        axr(`ACMC_OFF_IRQ_STAT);
        chk("status cleared", 32'h0, rd);
        axw(`ACMC_OFF_IRQ_MASK, 8'h01);
        axr(`ACMC_OFF_IRQ_MASK);
        chk("mask", 32'h1, rd);
        vin(900);
        cb("irq", 1, irq);
        vin(100);
        axw(`ACMC_OFF_IRQ_STAT, 8'h00);
        chk("stat write resp", {30'h0, `ACMC_RESP_OKAY}, {30'h0, rs});
        cb("irq held", 1, irq);
        axr(`ACMC_OFF_IRQ_STAT);
        chk("status", 32'h3, rd);
        repeat (2) @(posedge aclk);
        cb("irq", 0, irq);
    endtask

    task automatic t_bus();
        axr(12'h00C);
        chk("unmapped rresp", {30'h0, `ACMC_RESP_SLVERR}, {30'h0, rs});
        chk("unmapped rdata", 32'h0, rd);
        axw(12'h00C, 8'hFF);
        chk("unmapped bresp", {30'h0, `ACMC_RESP_SLVERR}, {30'h0, rs});
    endtask

    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1;
        t_reset();
        t_enable();
        t_level();
        t_edges();
        t_irq();
        t_bus();
        test_done();
    end
endmodule
